// ==== test/idc_dma_regs_chk.sv ====
`timescale 1ns/1ns
module idc_dma_regs_chk
(
    // clock and reset
    input wire logic core_clk,
    input wire logic sys_rst,
    // register window
    input wire logic [3:0] ioAddr,
    input wire logic ioWrite,
    input wire logic ioRead,
    input wire logic [7:0] ioWData,
    // engine and pins
    input wire logic holdAcknowledge,
    input wire logic [3:0] terminalCount,
    input wire logic [3:0] dmaAcknowledgeLine,
    // state
    input wire logic [7:0] busStatus,
    input wire logic [7:0] commandOut,
    input wire logic [3:0] maskOut,
    input wire logic [23:0] modeOut,
    input wire logic [15:0] ch3Count
);
    // ----------------------------------------
    // byte pointer and idle tracking
    // ----------------------------------------
    logic ptr_q;
    logic ptr_d;
    logic pol_q;
    logic [1:0] idle_q;
    logic [1:0] idle_d;
    always_comb
    begin
        ptr_d = ptr_q;
        if ((ioWrite || ioRead) && ioAddr == 4'h7)
            ptr_d = !ptr_q;
        if (ioWrite && ioAddr == 4'hC)
            ptr_d = 1'b0;
        idle_d = 2'h0;
        if ((commandOut[2] || !holdAcknowledge) && commandOut[7] == pol_q)
            idle_d = (idle_q == 2'h3) ? 2'h3 : idle_q + 2'h1;
    end
    always_ff @(posedge core_clk)
    begin
        ptr_q <= sys_rst ? 1'b0 : ptr_d;
        idle_q <= sys_rst ? 2'h0 : idle_d;
        pol_q <= sys_rst ? 1'b0 : commandOut[7];
    end
    // ----------------------------------------
    // properties
    // ----------------------------------------
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (sys_rst);
    a_count_low:
        assert property (ioWrite && ioAddr == 4'h7 && !ptr_q |=> ch3Count[7:0] == $past(ioWData))
        else $error("count low byte wrong");
    a_count_high:
        assert property (ioWrite && ioAddr == 4'h7 && ptr_q |=> ch3Count[15:8] == $past(ioWData))
        else $error("count high byte wrong");
    a_status_clear:
        assert property (ioRead && ioAddr == 4'h8 && terminalCount == 4'h0
            |=> busStatus[3:0] == 4'h0)
        else $error("count flags not cleared");
    a_tc_set:
        assert property (terminalCount != 4'h0
            |=> (busStatus[3:0] & $past(terminalCount)) == $past(terminalCount))
        else $error("count flag not set");
    a_cmd_load:
        assert property (ioWrite && ioAddr == 4'h8 |=> commandOut == $past(ioWData))
        else $error("command not loaded");
    a_mask_single:
        assert property (ioWrite && ioAddr == 4'hA
            |=> maskOut[$past(ioWData[1:0])] == $past(ioWData[2]))
        else $error("mask bit wrong");
    a_mode_select:
        assert property (ioWrite && ioAddr == 4'hB
            |=> modeOut[6 * $past(ioWData[1:0]) +: 6] == $past(ioWData[7:2]))
        else $error("mode field wrong");
    a_ack_idle:
        assert property (idle_q == 2'h3 |-> dmaAcknowledgeLine == {4{pol_q}})
        else $error("ack while idle");
endmodule
bind idc_dma_regs idc_dma_regs_chk u_chk (.*);

// ==== test/idc_periph_model.sv ====
`timescale 1ns/1ns
module idc_periph_model
(
    // clock
    input wire logic core_clk,
    // bench control
    input wire logic [3:0] want,
    input wire logic polLow,
    // dma pins
    input wire logic [3:0] dmaAcknowledgeLine,
    output logic [3:0] dmaRequestLine,
    output logic [3:0] gotAck
);
    // ----------------------------------------
    // request held until acknowledged
    // ----------------------------------------
    logic [3:0] done = 4'h0;
    always @(posedge core_clk)
        done <= (done | (dmaAcknowledgeLine ^ {4{polLow}})) & want;
    assign gotAck = done;
    assign dmaRequestLine = (want & ~done) ^ {4{polLow}};
endmodule

// ==== test/test_isa_dma_control_registers.sv ====
`timescale 1ns/1ns
module test_isa_dma_control_registers;
    // ----------------------------------------
    // signals and model state
    // ----------------------------------------
    logic core_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic [3:0] ioAddr = 4'h0;
    logic ioWrite = 1'b0;
    logic ioRead = 1'b0;
    logic [7:0] ioWData = 8'h00;
    logic [7:0] ioRData;
    logic [3:0] dmaRequestLine;
    logic [3:0] dmaAcknowledgeLine;
    logic holdAcknowledge = 1'b0;
    logic [3:0] terminalCount = 4'h0;
    logic [7:0] busStatus;
    logic [7:0] commandOut;
    logic [3:0] maskOut;
    logic [23:0] modeOut;
    logic [15:0] ch3Count;
    logic [3:0] want = 4'h0;
    logic polLow = 1'b0;
    logic [3:0] gotAck;
    logic [15:0] cnt;
    logic [23:0] mode = 24'h0;
    logic [3:0] msk = 4'hF;
    logic [7:0] d;
    int errors = 0;
    int checked = 0;
    int cycles = 0;
    int seed = 54619;
    idc_dma_regs DUT (.*);
    idc_periph_model peer (.core_clk(core_clk), .want(want), .polLow(polLow),
        .dmaAcknowledgeLine(dmaAcknowledgeLine), .dmaRequestLine(dmaRequestLine),
        .gotAck(gotAck));
    always #5 core_clk = ~core_clk;
    always @(posedge core_clk)
    begin
        cycles++;
        if (cycles == 5000)
        begin
            errors++;
            tally_and_finish();
        end
    end
    // ----------------------------------------
    // tasks
    // ----------------------------------------
    task automatic cmp(input logic [23:0] got, input logic [23:0] exp);
        checked++;
        if (got !== exp)
        begin
            errors++;
            $display("MISMATCH %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] v);
        @(negedge core_clk);
        ioAddr = a;
        ioWData = v;
        ioWrite = 1'b1;
        @(negedge core_clk);
        ioWrite = 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, input logic [7:0] e);
        @(negedge core_clk);
        ioAddr = a;
        ioRead = 1'b1;
        @(negedge core_clk);
        ioRead = 1'b0;
        cmp(ioRData, e);
    endtask
    task automatic waitAck(input logic [3:0] e);
        for (int k = 0; k < 40 && gotAck !== e; k++)
            @(negedge core_clk);
        cmp(gotAck, e);
    endtask
    task automatic tally_and_finish();
        $display("comparisons %0d errors %0d", checked, errors);
        if (errors == 0 && checked > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial
    begin
        repeat (10) @(negedge core_clk);
        sys_rst = 1'b0;
        cmp({commandOut, maskOut, busStatus, 4'h0}, 24'h00F000);
        for (int i = 0; i < 3; i++)
        begin
            cnt = 16'($random(seed));
            wr(4'hC, 8'h5A);
            wr(4'h7, cnt[7:0]);
            wr(4'h7, cnt[15:8]);
            cmp(ch3Count, cnt);
            rd(4'h7, cnt[7:0]);
            wr(4'hC, 8'h00);
            rd(4'h7, cnt[7:0]);
            rd(4'h7, cnt[15:8]);
        end
        for (int i = 0; i < 5; i++)
        begin
            d = (i == 4) ? 8'h00 : 8'($random(seed));
            wr(4'h8, d);
            cmp(commandOut, d);
        end
        for (int a = 0; a < 16; a++)
            if (a != 7 && a != 8)
                rd(4'(a), 8'h00);
        d = 8'($random(seed)) | 8'h01;
        @(negedge core_clk);
        terminalCount = d[3:0];
        @(negedge core_clk);
        terminalCount = 4'h0;
        @(negedge core_clk);
        cmp(busStatus, {4'h0, d[3:0]});
        rd(4'h8, {4'h0, d[3:0]});
        rd(4'h8, 8'h00);
        for (int i = 0; i < 8; i++)
        begin
            d = 8'(i ^ 4);
            msk[d[1:0]] = d[2];
            wr(4'hA, d);
            cmp(maskOut, msk);
        end
        for (int i = 0; i < 4; i++)
        begin
            d = {2'(i), 1'(i), 1'(i >> 1), 2'(i), 2'(i)};
            mode[6 * i +: 6] = d[7:2];
            wr(4'hB, d);
            cmp(modeOut, mode);
        end
        wr(4'h9, 8'hFF);
        rd(4'h8, 8'h80);
        wr(4'h9, 8'h03);
        rd(4'h8, 8'h80);
        rd(4'h8, 8'h00);
        holdAcknowledge = 1'b1;
        want = 4'h5;
        waitAck(4'h1);
        waitAck(4'h5);
        holdAcknowledge = 1'b0;
        want = 4'h0;
        rd(4'h8, 8'h50);
        wr(4'h8, 8'h04);
        holdAcknowledge = 1'b1;
        want = 4'h1;
        repeat (10) @(negedge core_clk);
        cmp({gotAck, dmaAcknowledgeLine}, 8'h00);
        holdAcknowledge = 1'b0;
        polLow = 1'b1;
        want = 4'h0;
        wr(4'h8, 8'hC0);
        repeat (4) @(negedge core_clk);
        holdAcknowledge = 1'b1;
        want = 4'h8;
        waitAck(4'h8);
        holdAcknowledge = 1'b0;
        want = 4'h0;
        wr(4'h8, 8'hD0);
        repeat (4) @(negedge core_clk);
        holdAcknowledge = 1'b1;
        want = 4'h2;
        waitAck(4'h2);
        want = 4'h9;
        waitAck(4'h8);
        waitAck(4'h9);
        tally_and_finish();
    end
endmodule

// ==== verilog/idc_arb_if.sv ====
`timescale 1ns/1ns
interface idc_arb_if;
    logic [3:0] req;
    logic rotate;
    logic enable;
    logic [3:0] grant;
    modport ctrl (output req, output rotate, output enable, input grant);
    modport arb (input req, input rotate, input enable, output grant);
endinterface

// ==== verilog/idc_arbiter.sv ====
`timescale 1ns/1ns
`include "idc_defines.svh"
module idc_arbiter
(
    // clock and reset
    input wire logic core_clk,
    input wire logic sys_rst,
    // arbitration
    idc_arb_if.arb arb
);
    logic [3:0] grant_q;
    logic [3:0] grant_d;
    logic [1:0] lowest_q;
    logic [1:0] lowest_d;
    logic [1:0] start;
    logic [1:0] idx;
    logic found;

    assign arb.grant = grant_q;

    // ---------------------------------------------------------------
    // priority choice
    // ---------------------------------------------------------------
    always_comb
    begin
        grant_d = grant_q;
        lowest_d = lowest_q;
        found = 1'b0;
        idx = 2'b00;
        // the channel holding the grant is the most recently serviced one
        for (int i = 0; i < 4; i++)
        begin
            if (grant_q[i])
            begin
                lowest_d = 2'(i);
            end
        end
        start = arb.rotate ? lowest_d + 2'b01 : 2'b00;
        if (!arb.enable)
        begin
            grant_d = 4'h0;
        end
        else if ((grant_q & arb.req) == 4'h0)
        begin
            grant_d = 4'h0;
            for (int i = 0; i < 4; i++)
            begin
                if (!found && arb.req[start + 2'(i)])
                begin
                    found = 1'b1;
                    idx = start + 2'(i);
                end
            end
            if (found)
            begin
                grant_d[idx] = 1'b1;
            end
        end
    end

    always_ff @(posedge core_clk)
    begin
        if (sys_rst)
        begin
            grant_q <= `IDC_RST_NIB;
            lowest_q <= `IDC_RST_LOWEST;
        end
        else
        begin
            grant_q <= grant_d;
            lowest_q <= lowest_d;
        end
    end
endmodule

// ==== verilog/idc_defines.svh ====
// Function
// - channel 3 count is one byte location, byte pointer picks low or high
// - status bits 7..4 show pending requests of channels 3..0
// - status bits 3..0 show terminal count reached of channels 3..0
// - reading status through the window clears request and count flags
// - same eight flags visible in a separate bus status register
// - command write: bit 7 ack polarity, bit 6 request polarity, 1 = low
// - command bits 5..0: write timing, rotate, compress, disable, hold, memory-to-memory
// - request write sets or clears software request of selected channel
// - single mask write sets or clears mask of selected channel
// - mode bits 7:6 transfer mode, bit 5 decrement, bit 4 auto-init
// - mode bits 3:2 transfer type, ignored for cascade or memory-to-memory
// - each mode write lands only in the channel chosen by bits 1:0
// - any write to clear location resets byte pointer
`ifndef IDC_DEFINES_SVH
`define IDC_DEFINES_SVH

// ---------------------------------------------------------------
// register offsets
// ---------------------------------------------------------------
`define IDC_ADDR_CH3_COUNT 4'h7
`define IDC_ADDR_STATUS 4'h8
`define IDC_ADDR_REQUEST 4'h9
`define IDC_ADDR_MASK 4'hA
`define IDC_ADDR_MODE 4'hB
`define IDC_ADDR_PTR_CLEAR 4'hC

// ---------------------------------------------------------------
// field positions
// ---------------------------------------------------------------
`define IDC_CMD_ACK_POL 7
`define IDC_CMD_REQ_POL 6
`define IDC_CMD_ROTATE 4
`define IDC_CMD_DISABLE 2
`define IDC_CMD_MEM_TO_MEM 0
`define IDC_SEL_SET 2
`define IDC_SEL_HI 1
`define IDC_SEL_LO 0
`define IDC_MODE_HI 7
`define IDC_MODE_LO 2
`define IDC_STAT_RQ_HI 7
`define IDC_STAT_RQ_LO 4
`define IDC_STAT_TC_HI 3
`define IDC_STAT_TC_LO 0

// ---------------------------------------------------------------
// reset values
// ---------------------------------------------------------------
`define IDC_RST_BYTE 8'h00
`define IDC_RST_COUNT 16'h0000
`define IDC_RST_MASK 4'hF
`define IDC_RST_NIB 4'h0
`define IDC_RST_MODE 6'h00
`define IDC_RST_LOWEST 2'h3

`endif

// ==== verilog/idc_dma_regs.sv ====
`timescale 1ns/1ns
`include "idc_defines.svh"
module idc_dma_regs
(
    // clock and reset
    input wire logic core_clk,
    input wire logic sys_rst,
    // isa i/o window
    input wire logic [3:0] ioAddr,
    input wire logic ioWrite,
    input wire logic ioRead,
    input wire logic [7:0] ioWData,
    output logic [7:0] ioRData,
    // dma pins
    input wire logic [3:0] dmaRequestLine,
    output logic [3:0] dmaAcknowledgeLine,
    // transfer engine side
    input wire logic holdAcknowledge,
    input wire logic [3:0] terminalCount,
    // state out
    output logic [7:0] busStatus,
    output logic [7:0] commandOut,
    output logic [3:0] maskOut,
    output logic [23:0] modeOut,
    output logic [15:0] ch3Count
);
    idc_arb_if arbIf ();

    logic [3:0] reqMeta_q;
    logic [3:0] reqSync_q;
    logic [7:0] rdata_q, rdata_d;
    logic [7:0] cmd_q, cmd_d;
    logic [3:0] mask_q, mask_d;
    logic [3:0] swReq_q, swReq_d;
    logic [3:0] rqFlag_q, rqFlag_d;
    logic [3:0] tcFlag_q, tcFlag_d;
    logic [15:0] count_q, count_d;
    logic bytePtr_q, bytePtr_d;
    logic [3:0] ack_q, ack_d;
    idc_pkg::idc_mode_t mode_q [4];
    idc_pkg::idc_mode_t mode_d [4];
    logic [3:0] hwReq;
    logic [3:0] pending;
    logic [1:0] sel;

    // ---------------------------------------------------------------
    // request pins and arbitration
    // ---------------------------------------------------------------
    always_ff @(posedge core_clk)
    begin
        if (sys_rst)
        begin
            reqMeta_q <= `IDC_RST_NIB;
            reqSync_q <= `IDC_RST_NIB;
        end
        else
        begin
            reqMeta_q <= dmaRequestLine;
            reqSync_q <= reqMeta_q;
        end
    end

    always_comb
    begin
        hwReq = reqSync_q ^ {4{cmd_q[`IDC_CMD_REQ_POL]}};
        pending = (hwReq & ~mask_q) | swReq_q;
    end

    assign arbIf.req = pending;
    assign arbIf.rotate = cmd_q[`IDC_CMD_ROTATE];
    assign arbIf.enable = ~cmd_q[`IDC_CMD_DISABLE] & holdAcknowledge;

    idc_arbiter u_arb
    (
        .core_clk(core_clk),
        .sys_rst(sys_rst),
        .arb(arbIf.arb)
    );

    // ---------------------------------------------------------------
    // register access
    // ---------------------------------------------------------------
    always_comb
    begin
        cmd_d = cmd_q;
        mask_d = mask_q;
        swReq_d = swReq_q;
        count_d = count_q;
        bytePtr_d = bytePtr_q;
        rdata_d = `IDC_RST_BYTE;
        mode_d = mode_q;
        rqFlag_d = rqFlag_q;
        tcFlag_d = tcFlag_q;
        sel = ioWData[`IDC_SEL_HI:`IDC_SEL_LO];
        ack_d = arbIf.grant ^ {4{cmd_q[`IDC_CMD_ACK_POL]}};
        if (ioRead)
        begin
            unique case (ioAddr)
                `IDC_ADDR_CH3_COUNT:
                begin
                    rdata_d = bytePtr_q ? count_q[15:8] : count_q[7:0];
                    bytePtr_d = ~bytePtr_q;
                end
                `IDC_ADDR_STATUS:
                begin
                    rdata_d = {rqFlag_q, tcFlag_q};
                    rqFlag_d = `IDC_RST_NIB;
                    tcFlag_d = `IDC_RST_NIB;
                end
                default:
                begin
                    rdata_d = `IDC_RST_BYTE;
                end
            endcase
        end
        if (ioWrite)
        begin
            unique case (ioAddr)
                `IDC_ADDR_CH3_COUNT:
                begin
                    if (bytePtr_q)
                    begin
                        count_d[15:8] = ioWData;
                    end
                    else
                    begin
                        count_d[7:0] = ioWData;
                    end
                    bytePtr_d = ~bytePtr_q;
                end
                `IDC_ADDR_STATUS:
                begin
                    cmd_d = ioWData;
                end
                `IDC_ADDR_REQUEST:
                begin
                    swReq_d[sel] = ioWData[`IDC_SEL_SET];
                end
                `IDC_ADDR_MASK:
                begin
                    mask_d[sel] = ioWData[`IDC_SEL_SET];
                end
                `IDC_ADDR_MODE:
                begin
                    mode_d[sel] = ioWData[`IDC_MODE_HI:`IDC_MODE_LO];
                end
                `IDC_ADDR_PTR_CLEAR:
                begin
                    bytePtr_d = 1'b0;
                end
                default:
                begin
                    bytePtr_d = bytePtr_d;
                end
            endcase
        end
        // events win over a clearing read
        rqFlag_d = rqFlag_d | pending;
        tcFlag_d = tcFlag_d | terminalCount;
    end

    always_ff @(posedge core_clk)
    begin
        if (sys_rst)
        begin
            cmd_q <= `IDC_RST_BYTE;
            mask_q <= `IDC_RST_MASK;
            swReq_q <= `IDC_RST_NIB;
            count_q <= `IDC_RST_COUNT;
            bytePtr_q <= 1'b0;
            rdata_q <= `IDC_RST_BYTE;
            rqFlag_q <= `IDC_RST_NIB;
            tcFlag_q <= `IDC_RST_NIB;
            ack_q <= `IDC_RST_NIB;
            for (int i = 0; i < 4; i++)
            begin
                mode_q[i] <= `IDC_RST_MODE;
            end
        end
        else
        begin
            cmd_q <= cmd_d;
            mask_q <= mask_d;
            swReq_q <= swReq_d;
            count_q <= count_d;
            bytePtr_q <= bytePtr_d;
            rdata_q <= rdata_d;
            rqFlag_q <= rqFlag_d;
            tcFlag_q <= tcFlag_d;
            ack_q <= ack_d;
            mode_q <= mode_d;
        end
    end

    // ---------------------------------------------------------------
    // outputs
    // ---------------------------------------------------------------
    assign ioRData = rdata_q;
    assign dmaAcknowledgeLine = ack_q;
    assign busStatus = {rqFlag_q, tcFlag_q};
    assign commandOut = cmd_q;
    assign maskOut = mask_q;
    assign modeOut = {mode_q[3], mode_q[2], mode_q[1], mode_q[0]};
    assign ch3Count = count_q;
endmodule

// ==== verilog/idc_pkg.sv ====
package idc_pkg;
    typedef logic [5:0] idc_mode_t;
    typedef enum logic [1:0]
    {
        IDC_DEMAND = 2'b00,
        IDC_SINGLE = 2'b01,
        IDC_BLOCK = 2'b10,
        IDC_CASCADE = 2'b11
    } idc_xfer_mode_e;
    typedef enum logic [1:0]
    {
        IDC_VERIFY = 2'b00,
        IDC_WRITE = 2'b01,
        IDC_READ = 2'b10,
        IDC_ILLEGAL = 2'b11
    } idc_xfer_type_e;
endpackage
